/* hw/bus_sync_tracker.sv */
// Tracks recessive runs on the bus to decide when the controller is synchronized.
`timescale 1ns/100ps
module bus_sync_tracker (
   // Clock and reset.
   input  wire logic   core_clk_i,
   input  wire logic   reset_n_i,
   // Link to the mode control core.
   sync_if.tracker     sif
);

   logic [3:0] run_q;
   logic [7:0] occ_q;
   logic       synced_q;

   // A completed run of recessive bits on this bit tick.
   wire run_done   = sif.bit_tick & (sif.rx_level == can_mode_pkg::RECESSIVE)
                     & (run_q == can_mode_pkg::RECESSIVE_RUN_LAST);
   // Bus-off needs the full count of runs before joining the bus.
   wire runs_done  = ~sif.bus_off | (occ_q == can_mode_pkg::BUS_OFF_RUNS_LAST);

   // Counts consecutive recessive bits; a dominant bit restarts the run.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         run_q    <= 4'h0;
         occ_q    <= 8'h00;
         synced_q <= 1'b0;
      end else if (sif.hold) begin
         run_q    <= 4'h0;
         occ_q    <= 8'h00;
         synced_q <= 1'b0;
      end else if (synced_q) begin
         synced_q <= ~sif.bus_off;
      end else if (sif.bit_tick) begin
         if (sif.rx_level != can_mode_pkg::RECESSIVE) begin
            run_q <= 4'h0;
         end else if (run_done) begin
            run_q    <= 4'h0;
            occ_q    <= runs_done ? 8'h00 : occ_q + 8'h01;
            synced_q <= runs_done;
         end else begin
            run_q <= run_q + 4'h1;
         end
      end
   end

   assign sif.synced = synced_q;

endmodule

/* hw/can_mode_control.sv */
// Mode and status control of a CAN protocol controller with its register port.
//
// Summary of operation
// - Mode register writable only outside init; status bits read-only; init request always writable.
// - Init mode holds mode register reset, except wake-up, sleep and init request.
// - Mode register writable again once init request and acknowledge are both zero.
// - Hardware sets received-frame flag on every valid received message; sticky.
// - Writing one clears the received-frame flag; writing zero does nothing.
// - Received-frame flag and receiver-active are meaningless during loopback.
// - Receiver-active reads one while receiving, zero when transmitting or idle.
// - Stop-in-wait set stops the bus interface clocks during wait mode.
// - Synchronized status is set and cleared by hardware only.
// - Timer enable runs a free 16-bit bit-rate counter used for time stamps.
// - After a valid frame end, the time stamp goes to buffer bytes 0x0E, 0x0F.
// - Disabled timer is cleared; timer enable is held low in init mode.
// - Wake-up enable lets bus traffic end sleep; set it before sleep entry.
// - Sleep entered only when idle: no reception, transmit buffers empty; then acknowledge.
// - Sleep request cannot be set while the wake-up interrupt flag is pending.
// - Sleep lasts until software clears it, or bus activity with wake-up enabled.
// - Init request enters init at once, aborts traffic, loses sync, acknowledges.
// - Init entry returns the flag, enable, abort and select registers to defaults.
// - Config, timing and acceptance registers are writable only in init mode.
// - After init, sync needs 11 recessive bits; bus-off needs 128 such runs.
// - Clearing sleep request is ignored until sleep mode is really entered.
// - Clearing init request is ignored until init mode is really entered.
// - Transmit pin goes recessive at once when init is requested.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module can_mode_control (
   // Clock and reset.
   input  wire logic                                  core_clk_i,
   input  wire logic                                  reset_n_i,
   // Register port.
   input  wire logic [can_mode_pkg::ADDR_W-1:0]       reg_addr_i,
   input  wire logic [can_mode_pkg::DATA_W-1:0]       reg_wdata_i,
   input  wire logic                                  reg_wr_i,
   input  wire logic                                  reg_rd_i,
   output logic      [can_mode_pkg::DATA_W-1:0]       reg_rdata_o,
   // Protocol engine status.
   input  wire logic                                  bit_tick_i,
   input  wire logic                                  rx_active_i,
   input  wire logic                                  rx_frame_ok_i,
   input  wire logic                                  tx_frame_ok_i,
   input  wire logic                                  tx_buffers_empty_i,
   input  wire logic                                  bus_off_i,
   input  wire logic                                  wakeup_irq_flag_i,
   input  wire logic                                  tx_bit_i,
   input  wire logic                                  cpu_wait_i,
   // Bus pins.
   input  wire logic                                  bus_rx_pin_i,
   output logic                                       bus_tx_pin_o,
   // Mode and configuration outputs.
   output logic                                       init_mode_o,
   output logic                                       init_entry_o,
   output logic                                       sleep_mode_o,
   output logic                                       bus_clk_stop_o,
   output logic                                       config_write_allow_o,
   output logic      [can_mode_pkg::CONFIG_W-1:0]     config_o,
   // Time stamp write to the message buffer.
   output logic                                       stamp_we_o,
   output logic      [7:0]                            stamp_offset_o,
   output logic      [can_mode_pkg::TIMER_W-1:0]      stamp_data_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic                                 frame_received_q;
   logic                                 receiver_active_q;
   logic                                 stop_in_wait_q;
   logic                                 timer_enable_q;
   logic                                 wakeup_enable_q;
   logic                                 sleep_request_q;
   logic                                 sleep_request_d;
   logic                                 sleep_ack_q;
   logic                                 sleep_ack_d;
   logic                                 init_request_q;
   logic                                 init_request_d;
   logic                                 init_ack_q;
   logic [can_mode_pkg::CONFIG_W-1:0]    config_q;
   logic [can_mode_pkg::TIMER_W-1:0]     timer_q;
   logic [can_mode_pkg::TIMER_W-1:0]     timer_d;
   logic                                 rx_meta_q;
   logic                                 rx_sync_q;
   logic [can_mode_pkg::DATA_W-1:0]      rdata_q;
   logic                                 tx_pin_q;
   logic                                 init_entry_q;
   logic                                 clk_stop_q;
   logic                                 cfg_allow_q;
   logic                                 stamp_we_q;
   logic [can_mode_pkg::TIMER_W-1:0]     stamp_data_q;

   sync_if sif ();

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------

   // Init mode proper is request and acknowledge both high.
   wire init_mode   = init_request_q & init_ack_q;
   // Reset hold starts with the request and ends when both bits are low.
   wire init_hold   = init_request_q | init_ack_q;
   wire init_out    = ~init_request_q & ~init_ack_q;
   wire sleep_mode  = sleep_request_q & sleep_ack_q;
   wire loopback    = config_q[can_mode_pkg::LOOPBACK_BIT - can_mode_pkg::CONFIG_LSB];
   // Bus is idle when nothing is received and nothing waits to be sent.
   wire bus_idle    = ~rx_active_i & tx_buffers_empty_i;
   // Any dominant level seen while asleep counts as bus activity.
   wire bus_wake    = sleep_mode & wakeup_enable_q
                      & (rx_sync_q == can_mode_pkg::DOMINANT);

   // ---------------------------------------------------------------
   // Register write decode
   // ---------------------------------------------------------------
   wire wr_mode     = reg_wr_i & (reg_addr_i == can_mode_pkg::MODE_CONTROL_OFF);
   wire wr_config   = reg_wr_i & (reg_addr_i == can_mode_pkg::CONFIG_CONTROL_OFF);
   wire mode_open   = wr_mode & init_out;
   wire config_open = wr_config & init_mode;
   wire w_frame     = reg_wdata_i[can_mode_pkg::FRAME_RECEIVED_BIT];
   wire w_stop      = reg_wdata_i[can_mode_pkg::STOP_IN_WAIT_BIT];
   wire w_timer     = reg_wdata_i[can_mode_pkg::TIMER_ENABLE_BIT];
   wire w_wakeup    = reg_wdata_i[can_mode_pkg::WAKEUP_ENABLE_BIT];
   wire w_sleep     = reg_wdata_i[can_mode_pkg::SLEEP_REQUEST_BIT];
   wire w_init      = reg_wdata_i[can_mode_pkg::INIT_REQUEST_BIT];
   wire [can_mode_pkg::CONFIG_W-1:0] w_config =
      reg_wdata_i[can_mode_pkg::DATA_W-1:can_mode_pkg::CONFIG_LSB];

   // ---------------------------------------------------------------
   // Read data selection
   // ---------------------------------------------------------------
   wire [can_mode_pkg::DATA_W-1:0] mode_view = {
      frame_received_q,
      receiver_active_q,
      stop_in_wait_q,
      sif.synced,
      timer_enable_q,
      wakeup_enable_q,
      sleep_request_q,
      init_request_q
   };
   wire [can_mode_pkg::DATA_W-1:0] config_view = {config_q, sleep_ack_q, init_ack_q};
   wire [can_mode_pkg::DATA_W-1:0] rd_mux =
      (reg_addr_i == can_mode_pkg::MODE_CONTROL_OFF)   ? mode_view :
      (reg_addr_i == can_mode_pkg::CONFIG_CONTROL_OFF) ? config_view :
      (reg_addr_i == can_mode_pkg::TIMER_HIGH_OFF)     ? timer_q[15:8] :
      (reg_addr_i == can_mode_pkg::TIMER_LOW_OFF)      ? timer_q[7:0] :
                                                         8'h00;

   // ---------------------------------------------------------------
   // Handshake next values
   // ---------------------------------------------------------------

   // Init request sets at any time; a clear waits for the acknowledge.
   assign init_request_d = wr_mode ? (w_init | (init_request_q & ~init_ack_q))
                                   : init_request_q;

   // Sleep request: wake-up clears it, set refused on pending wake-up flag.
   always_comb begin
      sleep_request_d = sleep_request_q;
      if (bus_wake) begin
         sleep_request_d = 1'b0;
      end else if (mode_open) begin
         if (w_sleep) begin
            sleep_request_d = sleep_request_q | ~wakeup_irq_flag_i;
         end else begin
            sleep_request_d = sleep_request_q & ~sleep_ack_q;
         end
      end
   end

   // Acknowledge follows the request once the bus has gone idle.
   assign sleep_ack_d = sleep_request_q & (sleep_ack_q | (bus_idle & ~init_hold));

   // Timer counts bit ticks while enabled and is zero otherwise.
   assign timer_d = ~timer_enable_q ? can_mode_pkg::TIMER_RESET :
                    bit_tick_i      ? timer_q + 16'h0001 : timer_q;

   // ---------------------------------------------------------------
   // Receive pin synchroniser
   // ---------------------------------------------------------------

   // Two stages before anything reads the receive pin.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_meta_q <= can_mode_pkg::RECESSIVE;
         rx_sync_q <= can_mode_pkg::RECESSIVE;
      end else begin
         rx_meta_q <= bus_rx_pin_i;
         rx_sync_q <= rx_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // Initialization and sleep handshakes
   // ---------------------------------------------------------------

   // Init acknowledge trails its request by one cycle in both directions; sleep acknowledge waits for idle to set.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         init_request_q  <= 1'b1;
         init_ack_q      <= 1'b1;
         sleep_request_q <= 1'b0;
         sleep_ack_q     <= 1'b0;
      end else begin
         init_request_q  <= init_request_d;
         init_ack_q      <= init_request_q;
         sleep_request_q <= sleep_request_d;
         sleep_ack_q     <= sleep_ack_d;
      end
   end

   // Wake-up enable survives init mode and is written outside of it.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wakeup_enable_q <= 1'b0;
      end else if (mode_open) begin
         wakeup_enable_q <= w_wakeup;
      end
   end

   // ---------------------------------------------------------------
   // Mode control bits held in reset during init
   // ---------------------------------------------------------------

   // Held bits reset while init is requested or acknowledged.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stop_in_wait_q <= 1'b0;
         timer_enable_q <= 1'b0;
      end else if (init_hold) begin
         stop_in_wait_q <= 1'b0;
         timer_enable_q <= 1'b0;
      end else if (mode_open) begin
         stop_in_wait_q <= w_stop;
         timer_enable_q <= w_timer;
      end
   end

   // Received-frame flag: a new frame wins over a clear in the same cycle.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         frame_received_q <= 1'b0;
      end else if (init_hold) begin
         frame_received_q <= 1'b0;
      end else if (rx_frame_ok_i) begin
         frame_received_q <= 1'b1;
      end else if (mode_open & w_frame) begin
         frame_received_q <= 1'b0;
      end
   end

   // Receiver-active mirrors the front end and reads zero in init.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         receiver_active_q <= 1'b0;
      end else begin
         receiver_active_q <= rx_active_i & ~init_hold;
      end
   end

   // ---------------------------------------------------------------
   // Config register and time-stamp timer
   // ---------------------------------------------------------------

   // Config bits accept writes only inside init mode.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         config_q <= can_mode_pkg::CONFIG_RESET;
      end else if (config_open) begin
         config_q <= w_config;
      end
   end

   // Free-running time-stamp counter.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         timer_q <= can_mode_pkg::TIMER_RESET;
      end else begin
         timer_q <= timer_d;
      end
   end

   // Stamp capture at the end of each valid transmitted or received frame.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stamp_we_q   <= 1'b0;
         stamp_data_q <= can_mode_pkg::TIMER_RESET;
      end else begin
         stamp_we_q   <= timer_enable_q & (rx_frame_ok_i | tx_frame_ok_i);
         stamp_data_q <= timer_q;
      end
   end

   // ---------------------------------------------------------------
   // Pin, clock gating and status outputs
   // ---------------------------------------------------------------

   // Transmit pin is forced recessive in init, sleep, stopped wait and loopback.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_pin_q <= can_mode_pkg::RECESSIVE;
      end else if (init_request_d | init_hold | sleep_mode | loopback
                   | (cpu_wait_i & stop_in_wait_q)) begin
         tx_pin_q <= can_mode_pkg::RECESSIVE;
      end else begin
         tx_pin_q <= tx_bit_i;
      end
   end

   // Entry pulse tells the flag, enable, abort and select registers to reset.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         init_entry_q <= 1'b0;
         clk_stop_q   <= 1'b0;
         cfg_allow_q  <= 1'b0;
      end else begin
         init_entry_q <= init_request_q & ~init_ack_q;
         clk_stop_q   <= cpu_wait_i & stop_in_wait_q;
         cfg_allow_q  <= init_request_d & init_request_q;
      end
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd_i ? rd_mux : 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Bus synchronisation tracker
   // ---------------------------------------------------------------

   // Init aborts traffic and drops sync; tracker restarts when init ends.
   assign sif.bit_tick = bit_tick_i;
   assign sif.rx_level = rx_sync_q;
   assign sif.hold     = init_hold;
   assign sif.bus_off  = bus_off_i;

   // Synchronized status is produced here and only read back by software.
   bus_sync_tracker u_tracker (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .sif        (sif)
   );

   // ---------------------------------------------------------------
   // Output assignments
   // ---------------------------------------------------------------
   assign reg_rdata_o          = rdata_q;
   assign bus_tx_pin_o         = tx_pin_q;
   assign init_mode_o          = init_ack_q;
   assign init_entry_o         = init_entry_q;
   assign sleep_mode_o         = sleep_ack_q;
   assign bus_clk_stop_o       = clk_stop_q;
   assign config_write_allow_o = cfg_allow_q;
   assign config_o             = config_q;
   assign stamp_we_o           = stamp_we_q;
   assign stamp_offset_o       = can_mode_pkg::STAMP_HIGH_OFFSET;
   assign stamp_data_o         = stamp_data_q;

endmodule

/* inc/can_mode_pkg.sv */
// Shared constants for the CAN mode and status control block.
package can_mode_pkg;

   // ---------------------------------------------------------------
   // Register port geometry
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] MODE_CONTROL_OFF   = 6'h00;
   localparam logic [ADDR_W-1:0] CONFIG_CONTROL_OFF = 6'h01;
   localparam logic [ADDR_W-1:0] TIMER_HIGH_OFF     = 6'h02;
   localparam logic [ADDR_W-1:0] TIMER_LOW_OFF      = 6'h03;

   // ---------------------------------------------------------------
   // Mode control field positions
   // ---------------------------------------------------------------
   localparam int unsigned FRAME_RECEIVED_BIT = 7;
   localparam int unsigned RECEIVER_ACTIVE_BIT = 6;
   localparam int unsigned STOP_IN_WAIT_BIT    = 5;
   localparam int unsigned SYNCHRONIZED_BIT    = 4;
   localparam int unsigned TIMER_ENABLE_BIT    = 3;
   localparam int unsigned WAKEUP_ENABLE_BIT   = 2;
   localparam int unsigned SLEEP_REQUEST_BIT   = 1;
   localparam int unsigned INIT_REQUEST_BIT    = 0;

   // ---------------------------------------------------------------
   // Config control field positions
   // ---------------------------------------------------------------
   localparam int unsigned CONFIG_LSB      = 2;
   localparam int unsigned CONFIG_W        = 6;
   localparam int unsigned LOOPBACK_BIT    = 5;
   localparam int unsigned SLEEP_ACK_BIT   = 1;
   localparam int unsigned INIT_ACK_BIT    = 0;
   localparam logic [CONFIG_W-1:0] CONFIG_RESET = 6'h00;

   // ---------------------------------------------------------------
   // Bus levels, timer and synchronisation counts
   // ---------------------------------------------------------------
   localparam logic RECESSIVE = 1'b1;
   localparam logic DOMINANT  = 1'b0;
   localparam int unsigned TIMER_W = 16;
   localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;
   localparam logic [7:0] STAMP_HIGH_OFFSET = 8'h0E;
   localparam logic [7:0] STAMP_LOW_OFFSET  = 8'h0F;
   localparam logic [3:0] RECESSIVE_RUN_LAST = 4'hA;
   localparam logic [7:0] BUS_OFF_RUNS_LAST  = 8'h7F;

endpackage

/* inc/sync_if.sv */
// Link between the mode control core and the bus synchronisation tracker.
`timescale 1ns/100ps
interface sync_if;
   logic bit_tick;
   logic rx_level;
   logic hold;
   logic bus_off;
   logic synced;

   modport ctrl    (output bit_tick, output rx_level, output hold, output bus_off,
                    input synced);
   modport tracker (input bit_tick, input rx_level, input hold, input bus_off,
                    output synced);
endinterface

/* sim/can_bus_node.sv */
// Bus model: remote nodes and the local transmitter share a wired-AND line.
`timescale 1ns/100ps
module can_bus_node (
   input  wire logic tx_pin_i,
   input  wire logic remote_dom_i,
   output logic      rx_pin_o
);
   // A remote dominant bit wins over a recessive local pin.
   assign rx_pin_o = tx_pin_i & ~remote_dom_i;
endmodule

/* sim/can_mode_control_asserts.sv */
// Port checker for the CAN mode control block.
`timescale 1ns/100ps
module can_mode_control_asserts (
   // Clock, reset and watched ports.
   input wire logic core_clk_i, reset_n_i, reg_rd_i, rx_active_i, tx_buffers_empty_i,
   input wire logic rx_frame_ok_i, tx_frame_ok_i, bus_tx_pin_o, init_mode_o, init_entry_o,
   input wire logic sleep_mode_o, stamp_we_o,
   input wire logic [7:0] reg_rdata_o, stamp_offset_o
);
   // All checks use the core clock and rest during reset.
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   a_read_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside slot");
   a_entry_ack: assert property ($rose(init_mode_o) |-> init_entry_o)
      else $error("no entry pulse");
   a_entry_cause: assert property (init_entry_o |-> init_mode_o && !$past(init_mode_o))
      else $error("stray entry pulse");
   a_entry_once: assert property (init_entry_o |=> !init_entry_o)
      else $error("long entry pulse");
   a_tx_init: assert property (init_mode_o |-> bus_tx_pin_o)
      else $error("tx dominant in init");
   a_sleep_idle: assert property ($rose(sleep_mode_o) |-> !$past(rx_active_i) && $past(tx_buffers_empty_i))
      else $error("sleep while busy");
   a_stamp_cause: assert property (stamp_we_o |-> $past(rx_frame_ok_i) || $past(tx_frame_ok_i))
      else $error("stamp without frame");
   a_stamp_offset: assert property (stamp_we_o |-> stamp_offset_o == 8'h0E)
      else $error("stamp offset");
endmodule
bind can_mode_control can_mode_control_asserts chk_u (.*);

/* sim/tb_top.sv */
// Self-checking bench for the CAN mode control block.
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch at %0t: got %h", $time, (g)); end end
module tb_top;
   logic core_clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, bit_tick_i = 0, dom = 0;
   logic rx_active_i = 0, rx_frame_ok_i = 0, tx_frame_ok_i = 0, bus_off_i = 0, cpu_wait_i = 0;
   logic tx_buffers_empty_i = 1, wakeup_irq_flag_i = 0, tx_bit_i = 1, bus_rx_pin_i, bus_tx_pin_o;
   logic init_mode_o, init_entry_o, sleep_mode_o, bus_clk_stop_o, config_write_allow_o, stamp_we_o;
   logic [5:0] reg_addr_i = 0, config_o;
   logic [7:0] reg_wdata_i = 0, reg_rdata_o, stamp_offset_o;
   logic [15:0] stamp_data_o;
   int error_cnt = 0, checked = 0, cyc = 0;
   can_mode_control dut_u (.*);
   can_bus_node bus_u (.tx_pin_i(bus_tx_pin_o), .remote_dom_i(dom), .rx_pin_o(bus_rx_pin_i));
   // Clock, and a guard that cuts a hang short.
   always #10 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) if (++cyc == 3000) begin error_cnt++; close_out(); end
   task automatic close_out();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic ck(int n); repeat (n) @(posedge core_clk_i); #1; endtask
   task automatic wr(logic [5:0] a, logic [7:0] d);
      reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1; @(posedge core_clk_i);
      reg_wr_i <= 1'b0; #1;
   endtask
   task automatic rd(logic [5:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
      reg_addr_i <= a; reg_rd_i <= 1'b1; @(posedge core_clk_i);
      reg_rd_i <= 1'b0; #1 `CHK(reg_rdata_o & m, e)
   endtask
   task automatic tk(int n);
      repeat (n) begin bit_tick_i <= 1'b1; ck(1); bit_tick_i <= 1'b0; ck(1); end
   endtask
   // Start in init mode: locked writes, then leave init mode.
   task automatic t_init();
      rd(6'h0, 8'h01);
      wr(6'h0, 8'hA9); rd(6'h0, 8'h01);
      wr(6'h1, 8'h80); rd(6'h1, 8'h81);
      `CHK(config_o, 6'h20)
      wr(6'h3F, 8'hFF); rd(6'h3F, 8'h00);
      wr(6'h0, 8'h00); ck(1); rd(6'h1, 8'h80);
      wr(6'h1, 8'h40); rd(6'h1, 8'h80);
      wr(6'h0, 8'h08); rd(6'h0, 8'h08);
   endtask
   // Timer, time stamp and the received-frame flag.
   task automatic t_timer();
      tk(3); rd(6'h3, 8'h03); rd(6'h2, 8'h00);
      rx_frame_ok_i <= 1'b1; ck(1); rx_frame_ok_i <= 1'b0; tx_frame_ok_i <= 1'b1;
      `CHK({stamp_we_o, stamp_data_o}, 17'h10003)
      ck(1); tx_frame_ok_i <= 1'b0; `CHK({stamp_we_o, stamp_data_o}, 17'h10003)
      ck(1); `CHK(stamp_we_o, 1'b0)
      rd(6'h0, 8'h88);
      wr(6'h0, 8'h08); rd(6'h0, 8'h88);
      wr(6'h0, 8'h88); rd(6'h0, 8'h08);
      wr(6'h0, 8'h00); ck(1); rd(6'h3, 8'h00);
   endtask
   // Synchronisation after exactly eleven recessive bits.
   task automatic t_sync();
      tk(7); rd(6'h0, 8'h00, 8'h10);
      tk(1); rd(6'h0, 8'h10, 8'h10);
      wr(6'h0, 8'h20); cpu_wait_i <= 1'b1; ck(2); `CHK(bus_clk_stop_o, 1'b1)
      cpu_wait_i <= 1'b0; ck(1); `CHK(bus_clk_stop_o, 1'b0)
   endtask
   // Sleep refusal, idle wait, locked clear and wake-up on traffic.
   task automatic t_sleep();
      wakeup_irq_flag_i <= 1'b1; wr(6'h0, 8'h06); rd(6'h0, 8'h04, 8'h06);
      wakeup_irq_flag_i <= 1'b0; rx_active_i <= 1'b1; wr(6'h0, 8'h06); wr(6'h0, 8'h04);
      rd(6'h0, 8'h46, 8'h46);
      `CHK(sleep_mode_o, 1'b0)
      rx_active_i <= 1'b0; ck(3); `CHK(sleep_mode_o, 1'b1)
      dom <= 1'b1; ck(4); dom <= 1'b0; rd(6'h0, 8'h00, 8'h02);
   endtask
   // Init request again while the pin is dominant.
   task automatic t_reinit();
      tx_bit_i <= 1'b0; ck(2); `CHK(bus_tx_pin_o, 1'b0)
      wr(6'h0, 8'h05); `CHK(bus_tx_pin_o, 1'b1)
      ck(1); `CHK({init_mode_o, init_entry_o, config_write_allow_o}, 3'b111)
      rd(6'h0, 8'h05);
   endtask
   // Reset for 20 cycles, then run the scenarios.
   initial begin
      repeat (20) @(posedge core_clk_i);
      reset_n_i <= 1'b1; ck(1);
      t_init(); t_timer(); t_sync(); t_sleep(); t_reinit();
      close_out();
   end
endmodule
